// File: logic/decoder_consts.vh
`ifndef DECODER_CONSTS_VH
`define DECODER_CONSTS_VH

// Register byte offsets
`define REG_INSTR 5'h00
`define REG_OPERAND 5'h04
`define REG_CTRL 5'h08
`define REG_CLASS 5'h0C
`define REG_FIELDS 5'h10

// Reset values
`define INSTR_RST 14'h0000
`define OPERAND_RST 8'h00
`define CTRL_RST 1'b0

// Instruction groups (top two bits)
`define GRP_BYTE 2'h0
`define GRP_BIT 2'h1
`define GRP_JUMP 2'h2
`define GRP_LIT 2'h3

// Instruction field positions
`define F_GRP_HI 13
`define F_GRP_LO 12
`define F_OPC_HI 11
`define F_OPC_LO 8
`define F_DEST 7
`define F_FILE_HI 6
`define F_BIT_HI 9
`define F_BIT_LO 7
`define F_BITOP_HI 11
`define F_BITOP_LO 10
`define F_JUMP_SEL 11
`define F_TGT_HI 10
`define F_LIT_HI 7

// Byte group operation codes
`define BOP_CTRL 4'h0
`define BOP_CLEAR 4'h1
`define BOP_SUB 4'h2
`define BOP_DEC 4'h3
`define BOP_OR 4'h4
`define BOP_AND 4'h5
`define BOP_XOR 4'h6
`define BOP_ADD 4'h7
`define BOP_MOVE 4'h8
`define BOP_COMP 4'h9
`define BOP_INC 4'hA
`define BOP_DECSKIP 4'hB
`define BOP_ROTR 4'hC
`define BOP_ROTL 4'hD
`define BOP_SWAP 4'hE
`define BOP_INCSKIP 4'hF

// Bit group operation codes
`define BITOP_CLEAR 2'h0
`define BITOP_SET 2'h1
`define BITOP_SKIPCLR 2'h2
`define BITOP_SKIPSET 2'h3

// Fixed control words, low seven bits
`define CW_RETURN 7'h08
`define CW_RETINT 7'h09
`define CW_STANDBY 7'h63
`define CW_WDOG 7'h64
`define CW_NOP_MASK 7'h1F
`define CW_NOP_VAL 7'h00

// Operation identifiers
`define OP_NOP 6'h00
`define OP_ADD_WORK_FILE 6'h01
`define OP_AND_WORK_FILE 6'h02
`define OP_CLEAR_FILE 6'h03
`define OP_CLEAR_WORK 6'h04
`define OP_COMP_FILE 6'h05
`define OP_DEC_FILE 6'h06
`define OP_DEC_SKIP_ZERO 6'h07
`define OP_INC_FILE 6'h08
`define OP_INC_SKIP_ZERO 6'h09
`define OP_OR_WORK_FILE 6'h0A
`define OP_MOVE_FILE 6'h0B
`define OP_MOVE_WORK_FILE 6'h0C
`define OP_ROT_LEFT 6'h0D
`define OP_ROT_RIGHT 6'h0E
`define OP_SUB_WORK_FILE 6'h0F
`define OP_SWAP_FILE 6'h10
`define OP_XOR_WORK_FILE 6'h11
`define OP_BIT_CLEAR 6'h12
`define OP_BIT_SET 6'h13
`define OP_TEST_SKIP_CLR 6'h14
`define OP_TEST_SKIP_SET 6'h15
`define OP_ADD_LIT 6'h16
`define OP_AND_LIT 6'h17
`define OP_CALL 6'h18
`define OP_WDOG_CLEAR 6'h19
`define OP_JUMP 6'h1A
`define OP_OR_LIT 6'h1B
`define OP_MOVE_LIT 6'h1C
`define OP_RET_INT 6'h1D
`define OP_RET_LIT 6'h1E
`define OP_RETURN 6'h1F
`define OP_STANDBY 6'h20
`define OP_SUB_FROM_LIT 6'h21
`define OP_XOR_LIT 6'h22
`define OP_ILLEGAL 6'h3F

// Flag mask bits {carry, digit carry, zero, timeout, powerdown}
`define FM_NONE 5'h00
`define FM_ARITH 5'h1C
`define FM_ZERO 5'h04
`define FM_CARRY 5'h10
`define FM_POWER 5'h03

// Special file addresses
`define ADDR_TIMER0 7'h01
`define ADDR_PORT_LO 7'h05
`define ADDR_PORT_HI 7'h09

// Cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2

// Class register field positions
`define CL_GROUP 0
`define CL_OP 2
`define CL_DEST 8
`define CL_CYC 9
`define CL_SKIP 11
`define CL_PCMOD 12
`define CL_PINS 13
`define CL_PRESC 14
`define CL_ILLEGAL 15
`define CL_FLAGS 16
`define CL_RET 21

// Fields register positions
`define FD_FILE 0
`define FD_BIT 7
`define FD_LIT 10
`define FD_TGT 18

`endif

// File: logic/instr_classify.v
`timescale 1ns/1ps
`include "decoder_consts.vh"

module instr_classify (
	// Instruction word
	input wire [13:0] word,
	// Classification
	output reg [1:0] group,
	output reg [5:0] op_id
);

	wire [3:0] bop;
	wire [1:0] bitop;
	wire [6:0] low7;

	assign bop = word[`F_OPC_HI:`F_OPC_LO];
	assign bitop = word[`F_BITOP_HI:`F_BITOP_LO];
	assign low7 = word[`F_FILE_HI:0];

	// Map the word onto one operation identifier
	always @* begin
		group = word[`F_GRP_HI:`F_GRP_LO];
		op_id = `OP_ILLEGAL;
		case (word[`F_GRP_HI:`F_GRP_LO])
			`GRP_BYTE: begin
				case (bop)
					`BOP_CTRL: begin
						if (word[`F_DEST])
							op_id = `OP_MOVE_WORK_FILE;
						else if ((low7 & `CW_NOP_MASK) == `CW_NOP_VAL)
							op_id = `OP_NOP;
						else if (low7 == `CW_RETURN)
							op_id = `OP_RETURN;
						else if (low7 == `CW_RETINT)
							op_id = `OP_RET_INT;
						else if (low7 == `CW_STANDBY)
							op_id = `OP_STANDBY;
						else if (low7 == `CW_WDOG)
							op_id = `OP_WDOG_CLEAR;
						else
							op_id = `OP_ILLEGAL;
					end
					`BOP_CLEAR: op_id = word[`F_DEST] ? `OP_CLEAR_FILE : `OP_CLEAR_WORK;
					`BOP_SUB: op_id = `OP_SUB_WORK_FILE;
					`BOP_DEC: op_id = `OP_DEC_FILE;
					`BOP_OR: op_id = `OP_OR_WORK_FILE;
					`BOP_AND: op_id = `OP_AND_WORK_FILE;
					`BOP_XOR: op_id = `OP_XOR_WORK_FILE;
					`BOP_ADD: op_id = `OP_ADD_WORK_FILE;
					`BOP_MOVE: op_id = `OP_MOVE_FILE;
					`BOP_COMP: op_id = `OP_COMP_FILE;
					`BOP_INC: op_id = `OP_INC_FILE;
					`BOP_DECSKIP: op_id = `OP_DEC_SKIP_ZERO;
					`BOP_ROTR: op_id = `OP_ROT_RIGHT;
					`BOP_ROTL: op_id = `OP_ROT_LEFT;
					`BOP_SWAP: op_id = `OP_SWAP_FILE;
					default: op_id = `OP_INC_SKIP_ZERO;
				endcase
			end
			`GRP_BIT: begin
				case (bitop)
					`BITOP_CLEAR: op_id = `OP_BIT_CLEAR;
					`BITOP_SET: op_id = `OP_BIT_SET;
					`BITOP_SKIPCLR: op_id = `OP_TEST_SKIP_CLR;
					default: op_id = `OP_TEST_SKIP_SET;
				endcase
			end
			`GRP_JUMP: begin
				op_id = word[`F_JUMP_SEL] ? `OP_JUMP : `OP_CALL;
			end
			default: begin
				casez (bop)
					4'b00??: op_id = `OP_MOVE_LIT;
					4'b01??: op_id = `OP_RET_LIT;
					4'b1000: op_id = `OP_OR_LIT;
					4'b1001: op_id = `OP_AND_LIT;
					4'b1010: op_id = `OP_XOR_LIT;
					4'b110?: op_id = `OP_SUB_FROM_LIT;
					4'b111?: op_id = `OP_ADD_LIT;
					default: op_id = `OP_ILLEGAL;
				endcase
			end
		endcase
	end

endmodule // instr_classify

// File: logic/risc_instruction_decoder.v
// Notes on behaviour
// - Top bits 00: opcode, destination, file address
// - Add, subtract hit C,DC,Z; logic ops Z
// - Rotates pass through carry, change carry only
// - Decrement/increment skip on zero, no flags
// - Bit tests skip on clear or set
// - Literal ops use low byte, decode patterns
// - Subtract-from-literal updates C, DC, Z
// - Return with literal loads W, two cycles
// - Standby and watchdog clear touch timeout, powerdown
// - Port read-modify-write reads pins, not latch
// - Timer write clears assigned prescaler
// - PC change or true test: two cycles
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "decoder_consts.vh"

module risc_instruction_decoder (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Avalon-MM slave
	input wire [4:0] avs_address,
	input wire [3:0] avs_byteenable,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Flags that each operation updates
	function [4:0] flag_mask;
		input [5:0] op;
		begin
			case (op)
				`OP_ADD_WORK_FILE,
				`OP_SUB_WORK_FILE,
				`OP_ADD_LIT,
				`OP_SUB_FROM_LIT: flag_mask = `FM_ARITH;
				`OP_ROT_LEFT,
				`OP_ROT_RIGHT: flag_mask = `FM_CARRY;
				`OP_AND_WORK_FILE,
				`OP_OR_WORK_FILE,
				`OP_XOR_WORK_FILE,
				`OP_CLEAR_FILE,
				`OP_CLEAR_WORK,
				`OP_COMP_FILE,
				`OP_DEC_FILE,
				`OP_INC_FILE,
				`OP_MOVE_FILE,
				`OP_OR_LIT,
				`OP_AND_LIT,
				`OP_XOR_LIT: flag_mask = `FM_ZERO;
				`OP_STANDBY,
				`OP_WDOG_CLEAR: flag_mask = `FM_POWER;
				default: flag_mask = `FM_NONE;
			endcase
		end
	endfunction

	// True for addresses of the I/O port registers
	function is_port;
		input [6:0] addr;
		begin
			is_port = (addr >= `ADDR_PORT_LO) && (addr <= `ADDR_PORT_HI);
		end
	endfunction

	// Merge write data into a register by byte lanes
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] be;
		integer i;
		begin
			lane_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					lane_merge[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reset release

	reg rst_meta_q;
	reg rst_sync_q;

	// Assert at once, release after two edges
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers

	reg [13:0] instr_q;
	reg [7:0] operand_q;
	reg presc_t0_q;
	reg ack_q;
	reg [31:0] readdata_q;
	wire access;
	wire wr_take;
	wire [31:0] instr_merged;
	wire [31:0] operand_merged;
	wire [31:0] ctrl_merged;

	assign access = avs_read | avs_write;
	// One wait cycle on every access
	assign avs_waitrequest = access & ~ack_q;
	assign wr_take = avs_write & ack_q;
	assign avs_readdata = readdata_q;

	assign instr_merged = lane_merge({18'h00000, instr_q}, avs_writedata, avs_byteenable);
	assign operand_merged = lane_merge({24'h000000, operand_q}, avs_writedata, avs_byteenable);
	assign ctrl_merged = lane_merge({31'h00000000, presc_t0_q}, avs_writedata, avs_byteenable);

	// Bus handshake and register writes
	always @(posedge clk_sys or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ack_q <= 1'b0;
			instr_q <= `INSTR_RST;
			operand_q <= `OPERAND_RST;
			presc_t0_q <= `CTRL_RST;
		end else begin
			ack_q <= access & ~ack_q;
			if (wr_take) begin
				case (avs_address)
					`REG_INSTR: instr_q <= instr_merged[13:0];
					`REG_OPERAND: operand_q <= operand_merged[7:0];
					`REG_CTRL: presc_t0_q <= ctrl_merged[0];
					default: ; // Read-only or unmapped: ignored
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field extraction

	wire [1:0] group;
	wire [5:0] op_id;
	wire dest_bit;
	wire [6:0] file_addr;
	wire [2:0] bit_idx;
	wire [7:0] literal;
	wire [10:0] target;

	instr_classify u_classify (
		.word(instr_q),
		.group(group),
		.op_id(op_id)
	);

	assign dest_bit = instr_q[`F_DEST];
	assign file_addr = instr_q[`F_FILE_HI:0];
	assign bit_idx = instr_q[`F_BIT_HI:`F_BIT_LO];
	assign literal = instr_q[`F_LIT_HI:0];
	assign target = instr_q[`F_TGT_HI:0];

	////////////////////////////////////////////////////////////////////////////////
	// Decode results

	reg dest_file;
	reg writes_file;
	reg reads_file;
	reg pc_mod;
	reg returns;
	reg skip;
	reg [1:0] cycles;
	reg pins_read;
	reg presc_clr;
	reg illegal;
	reg [4:0] flags;
	wire [7:0] dec_val;
	wire [7:0] inc_val;
	wire tested_bit;

	assign dec_val = operand_q - 8'h01;
	assign inc_val = operand_q + 8'h01;
	assign tested_bit = operand_q[bit_idx];

	// Destination, control flow, skip and side effects
	always @* begin
		dest_file = 1'b0;
		writes_file = 1'b0;
		reads_file = 1'b0;
		pc_mod = 1'b0;
		returns = 1'b0;
		skip = 1'b0;
		illegal = (op_id == `OP_ILLEGAL);
		flags = flag_mask(op_id);
		case (group)
			`GRP_BYTE: begin
				// Bit 7 set sends the result back to the file
				dest_file = dest_bit;
				writes_file = dest_bit && !illegal && (op_id != `OP_NOP);
				reads_file = (op_id != `OP_MOVE_WORK_FILE) && (op_id != `OP_CLEAR_FILE);
				if (op_id == `OP_DEC_SKIP_ZERO)
					skip = (dec_val == 8'h00);
				if (op_id == `OP_INC_SKIP_ZERO)
					skip = (inc_val == 8'h00);
				if ((op_id == `OP_RETURN) || (op_id == `OP_RET_INT)) begin
					pc_mod = 1'b1;
					returns = 1'b1;
					dest_file = 1'b0;
					writes_file = 1'b0;
				end
				if ((op_id == `OP_STANDBY) || (op_id == `OP_WDOG_CLEAR)) begin
					dest_file = 1'b0;
					writes_file = 1'b0;
				end
			end
			`GRP_BIT: begin
				reads_file = 1'b1;
				if ((op_id == `OP_BIT_CLEAR) || (op_id == `OP_BIT_SET)) begin
					dest_file = 1'b1;
					writes_file = 1'b1;
				end
				if (op_id == `OP_TEST_SKIP_CLR)
					skip = ~tested_bit;
				if (op_id == `OP_TEST_SKIP_SET)
					skip = tested_bit;
			end
			`GRP_JUMP: begin
				pc_mod = 1'b1;
			end
			default: begin
				if (op_id == `OP_RET_LIT) begin
					pc_mod = 1'b1;
					returns = 1'b1;
				end
			end
		endcase
		// Port rewrite takes its operand from the pins
		pins_read = writes_file && reads_file && is_port(file_addr);
		// Writing the timer register clears its prescaler
		presc_clr = writes_file && (file_addr == `ADDR_TIMER0) && presc_t0_q;
		// Taken branch or true test costs a trailing no-op cycle
		cycles = (pc_mod || skip) ? `CYC_TWO : `CYC_ONE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data

	reg [31:0] class_word;
	reg [31:0] field_word;
	reg [31:0] read_mux;

	// Pack decode results into the status words
	always @* begin
		class_word = 32'h00000000;
		class_word[`CL_GROUP +: 2] = group;
		class_word[`CL_OP +: 6] = op_id;
		class_word[`CL_DEST] = dest_file;
		class_word[`CL_CYC +: 2] = cycles;
		class_word[`CL_SKIP] = skip;
		class_word[`CL_PCMOD] = pc_mod;
		class_word[`CL_PINS] = pins_read;
		class_word[`CL_PRESC] = presc_clr;
		class_word[`CL_ILLEGAL] = illegal;
		class_word[`CL_FLAGS +: 5] = flags;
		class_word[`CL_RET] = returns;
		field_word = 32'h00000000;
		field_word[`FD_FILE +: 7] = file_addr;
		field_word[`FD_BIT +: 3] = bit_idx;
		field_word[`FD_LIT +: 8] = literal;
		field_word[`FD_TGT +: 11] = target;
	end

	// Select the register addressed by the bus
	always @* begin
		case (avs_address)
			`REG_INSTR: read_mux = {18'h00000, instr_q};
			`REG_OPERAND: read_mux = {24'h000000, operand_q};
			`REG_CTRL: read_mux = {31'h00000000, presc_t0_q};
			`REG_CLASS: read_mux = class_word;
			`REG_FIELDS: read_mux = field_word;
			default: read_mux = 32'h00000000;
		endcase
	end

	// Capture read data during the wait cycle
	always @(posedge clk_sys or negedge rst_sync_q) begin
		if (!rst_sync_q)
			readdata_q <= 32'h00000000;
		else if (avs_read && !ack_q)
			readdata_q <= read_mux;
	end

endmodule // risc_instruction_decoder

// File: tb/decoder_checker_props.sv
`timescale 1ns/1ps
`include "decoder_consts.vh"

module decoder_checker (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Avalon-MM slave
	input wire [4:0] avs_address,
	input wire [3:0] avs_byteenable,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest
);
	logic [13:0] instr_q;
	logic [7:0] oper_q;
	logic ctrl_q;
	wire wr_ok = avs_write && !avs_waitrequest;
	wire rd_ok = avs_read && !avs_waitrequest;
	wire cls_rd = rd_ok && avs_address == `REG_CLASS;
	wire byte_grp = instr_q[13:12] == `GRP_BYTE;
	wire [3:0] opc = instr_q[11:8];
	wire [4:0] fl = avs_readdata[20:16];
	wire [1:0] cyc = avs_readdata[10:9];
	wire skp = avs_readdata[11];

	// Shadow of the writable registers, updated at the accepting edge
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			instr_q <= `INSTR_RST;
			oper_q <= `OPERAND_RST;
			ctrl_q <= `CTRL_RST;
		end else if (wr_ok) begin
			if (avs_address == `REG_INSTR && avs_byteenable[0]) instr_q[7:0] <= avs_writedata[7:0];
			if (avs_address == `REG_INSTR && avs_byteenable[1]) instr_q[13:8] <= avs_writedata[13:8];
			if (avs_address == `REG_OPERAND && avs_byteenable[0]) oper_q <= avs_writedata[7:0];
			if (avs_address == `REG_CTRL && avs_byteenable[0]) ctrl_q <= avs_writedata[0];
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// A request waits exactly one cycle
	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_answer;
		!avs_waitrequest && (avs_read || avs_write);
	endsequence

	a_wait_one: assert property (s_req_wait |=> s_answer)
		else $error("waitrequest held past first cycle");
	a_group_field: assert property (cls_rd |-> avs_readdata[1:0] == instr_q[13:12])
		else $error("group field differs from top bits");
	a_dest_route: assert property (cls_rd && byte_grp |-> avs_readdata[8] == instr_q[7])
		else $error("destination differs from d bit");
	a_arith_flags: assert property (cls_rd && byte_grp && (opc == `BOP_ADD || opc == `BOP_SUB)
		|-> fl == `FM_ARITH)
		else $error("add or subtract flag mask wrong");
	a_rot_carry: assert property (cls_rd && byte_grp && opc[3:1] == 3'h6 |-> fl == `FM_CARRY)
		else $error("rotate flag mask wrong");
	a_skip_zero: assert property (cls_rd && byte_grp && opc == `BOP_DECSKIP
		|-> fl == `FM_NONE && skp == (oper_q == 8'h01))
		else $error("decrement skip decision wrong");
	a_bit_skip: assert property (cls_rd && instr_q[13:12] == `GRP_BIT && instr_q[11]
		|-> skp == (oper_q[instr_q[9:7]] == instr_q[10]))
		else $error("bit test skip decision wrong");
	a_skip_cycles: assert property (cls_rd && skp |-> cyc == `CYC_TWO)
		else $error("skip without second cycle");
	a_jump_two: assert property (cls_rd && instr_q[13:12] == `GRP_JUMP
		|-> cyc == `CYC_TWO && avs_readdata[12])
		else $error("call or jump not two cycles");
	a_lit_field: assert property (rd_ok && avs_address == `REG_FIELDS && instr_q[13:12] == `GRP_LIT
		|-> avs_readdata[17:10] == instr_q[7:0])
		else $error("literal field differs from low byte");
	a_power_flags: assert property (cls_rd && (instr_q == 14'h0063 || instr_q == 14'h0064)
		|-> fl == `FM_POWER && cyc == `CYC_ONE)
		else $error("standby or watchdog flags wrong");
	a_presc_clear: assert property (cls_rd && byte_grp && opc == `BOP_ADD && instr_q[7]
		&& instr_q[6:0] == `ADDR_TIMER0 |-> avs_readdata[14] == ctrl_q)
		else $error("prescaler clear wrong");
endmodule // decoder_checker

bind risc_instruction_decoder decoder_checker u_checker (.clk_sys(clk_sys), .reset_n(reset_n),
	.avs_address(avs_address), .avs_byteenable(avs_byteenable), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest));

// File: tb/prog_mem_model.sv
`timescale 1ns/1ps

module prog_mem_model (
	// Fetch port
	input wire [3:0] fetch_addr,
	output logic [13:0] fetch_word
);
	// Literal and control words handed to the decoder
	always_comb begin
		case (fetch_addr)
			4'h0: fetch_word = 14'h385A;
			4'h1: fetch_word = 14'h39A5;
			4'h2: fetch_word = 14'h3AC3;
			4'h3: fetch_word = 14'h3D3C;
			4'h4: fetch_word = 14'h3E7E;
			4'h5: fetch_word = 14'h3781;
			4'h6: fetch_word = 14'h2123;
			4'h7: fetch_word = 14'h2FFF;
			4'h8: fetch_word = 14'h0063;
			4'h9: fetch_word = 14'h0064;
			default: fetch_word = 14'h0000;
		endcase
	end
endmodule // prog_mem_model

// File: tb/risc_instruction_decoder_tb_top.sv
`timescale 1ns/1ps
`include "decoder_consts.vh"

module risc_instruction_decoder_tb_top;
	logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [3:0] avs_byteenable, fetch_addr;
	logic [31:0] avs_writedata, avs_readdata, cls, fld, rd;
	logic [13:0] fetch_word;
	int errors, checks_done;

	risc_instruction_decoder u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.avs_address(avs_address), .avs_byteenable(avs_byteenable), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	prog_mem_model u_mem (.fetch_addr(fetch_addr), .fetch_word(fetch_word));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic finish_test();
		if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One bus cycle: hold until waitrequest is seen low, then release
	task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 50) begin
			check("waitrequest", 32'h0, 32'h1);
			finish_test();
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus_xfer(1'b1, a, d, x);
	endtask

	task automatic decode(input logic [13:0] w, input logic [7:0] op);
		wr_reg(`REG_OPERAND, {24'h0, op});
		wr_reg(`REG_INSTR, {18'h0, w});
		bus_xfer(1'b0, `REG_CLASS, 32'h0, cls);
		bus_xfer(1'b0, `REG_FIELDS, 32'h0, fld);
	endtask

	// Reset values, unmapped place, read-only write, unused instruction bits
	task automatic test_reset_map();
		bus_xfer(1'b0, `REG_INSTR, 32'h0, rd);
		check("instr", 32'h0, rd);
		bus_xfer(1'b0, `REG_CTRL, 32'h0, rd);
		check("ctrl", 32'h0, rd);
		wr_reg(5'h14, 32'hFFFFFFFF);
		bus_xfer(1'b0, 5'h14, 32'h0, rd);
		check("unmapped", 32'h0, rd);
		wr_reg(`REG_CLASS, 32'hFFFFFFFF);
		bus_xfer(1'b0, `REG_CLASS, 32'h0, rd);
		check("class ro", 32'h00000200, rd);
		wr_reg(`REG_INSTR, 32'hFFFFFFFF);
		bus_xfer(1'b0, `REG_INSTR, 32'h0, rd);
		check("instr bits", 32'h00003FFF, rd);
	endtask

	// Byte operations with both destinations
	task automatic test_byte_ops();
		logic [3:0] opc_t[7] = '{4'h7, 4'h2, 4'h5, 4'h4, 4'h6, 4'hD, 4'hC};
		logic [5:0] id_t[7] = '{`OP_ADD_WORK_FILE, `OP_SUB_WORK_FILE, `OP_AND_WORK_FILE,
			`OP_OR_WORK_FILE, `OP_XOR_WORK_FILE, `OP_ROT_LEFT, `OP_ROT_RIGHT};
		logic [4:0] fm_t[7] = '{`FM_ARITH, `FM_ARITH, `FM_ZERO, `FM_ZERO, `FM_ZERO,
			`FM_CARRY, `FM_CARRY};
		for (int i = 0; i < 14; i++) begin
			decode({2'h0, opc_t[i / 2], i[0], 7'h20}, 8'h00);
			check("group", 32'h0, {30'h0, cls[1:0]});
			check("op id", {26'h0, id_t[i / 2]}, {26'h0, cls[7:2]});
			check("flags", {27'h0, fm_t[i / 2]}, {27'h0, cls[20:16]});
			check("dest", {31'h0, i[0]}, {31'h0, cls[8]});
			check("file", 32'h20, {25'h0, fld[6:0]});
		end
	endtask

	// Conditional skips on both outcomes
	task automatic test_skips();
		logic [13:0] w_t[8] = '{14'h0BA0, 14'h0BA0, 14'h0F20, 14'h0F20,
			14'h1DA0, 14'h1DA0, 14'h1BA0, 14'h1BA0};
		logic [7:0] op_t[8] = '{8'h01, 8'h05, 8'hFF, 8'h00, 8'h08, 8'hF7, 8'h7F, 8'h80};
		for (int i = 0; i < 8; i++) begin
			decode(w_t[i], op_t[i]);
			check("skip", {31'h0, !i[0]}, {31'h0, cls[11]});
			check("cycles", i[0] ? 32'h1 : 32'h2, {30'h0, cls[10:9]});
			check("flags", 32'h0, {27'h0, cls[20:16]});
			if (i >= 4) check("bit", {29'h0, w_t[i][9:7]}, {29'h0, fld[9:7]});
		end
	endtask

	// Literal, branch and fixed control words from program memory
	task automatic test_literals();
		logic [13:0] w;
		logic [5:0] id_t[10] = '{`OP_OR_LIT, `OP_AND_LIT, `OP_XOR_LIT, `OP_SUB_FROM_LIT,
			`OP_ADD_LIT, `OP_RET_LIT, `OP_CALL, `OP_JUMP, `OP_STANDBY, `OP_WDOG_CLEAR};
		logic [4:0] fm_t[10] = '{`FM_ZERO, `FM_ZERO, `FM_ZERO, `FM_ARITH, `FM_ARITH,
			`FM_NONE, `FM_NONE, `FM_NONE, `FM_POWER, `FM_POWER};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			fetch_addr <= i[3:0];
			@(negedge clk_sys);
			w = fetch_word;
			decode(w, 8'h00);
			check("op id", {26'h0, id_t[i]}, {26'h0, cls[7:2]});
			check("flags", {27'h0, fm_t[i]}, {27'h0, cls[20:16]});
			check("cycles", (i >= 5 && i <= 7) ? 32'h2 : 32'h1, {30'h0, cls[10:9]});
			if (i < 6) check("literal", {24'h0, w[7:0]}, {24'h0, fld[17:10]});
			if (i == 6 || i == 7) check("target", {21'h0, w[10:0]}, {21'h0, fld[28:18]});
		end
	endtask

	// Remaining codes: control words, clears, moves, illegal word, return flags
	task automatic test_misc_ops();
		logic [13:0] w_t[13] = '{14'h3012, 14'h0008, 14'h0009, 14'h0001, 14'h0180,
			14'h0100, 14'h09A0, 14'h0320, 14'h0AA0, 14'h08A0, 14'h0EA0, 14'h0000, 14'h3781};
		logic [5:0] id_t[13] = '{`OP_MOVE_LIT, `OP_RETURN, `OP_RET_INT, `OP_ILLEGAL,
			`OP_CLEAR_FILE, `OP_CLEAR_WORK, `OP_COMP_FILE, `OP_DEC_FILE, `OP_INC_FILE,
			`OP_MOVE_FILE, `OP_SWAP_FILE, `OP_NOP, `OP_RET_LIT};
		logic [4:0] fm_t[13] = '{`FM_NONE, `FM_NONE, `FM_NONE, `FM_NONE, `FM_ZERO,
			`FM_ZERO, `FM_ZERO, `FM_ZERO, `FM_ZERO, `FM_ZERO, `FM_NONE, `FM_NONE, `FM_NONE};
		// Expected {return, illegal, pc modified, cycles}
		logic [4:0] s_t[13] = '{5'h01, 5'h16, 5'h16, 5'h09, 5'h01, 5'h01, 5'h01, 5'h01,
			5'h01, 5'h01, 5'h01, 5'h01, 5'h16};
		for (int i = 0; i < 13; i++) begin
			decode(w_t[i], 8'h00);
			check("op id", {26'h0, id_t[i]}, {26'h0, cls[7:2]});
			check("flags", {27'h0, fm_t[i]}, {27'h0, cls[20:16]});
			check("status", {27'h0, s_t[i]}, {27'h0, cls[21], cls[15], cls[12], cls[10:9]});
		end
	endtask

	// Reset in mid-run clears read data and returns the word to its reset value
	task automatic test_mid_reset();
		wr_reg(`REG_INSTR, 32'h00003781);
		bus_xfer(1'b0, `REG_INSTR, 32'h0, rd);
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check("readdata in reset", 32'h0, avs_readdata);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bus_xfer(1'b0, `REG_INSTR, 32'h0, rd);
		check("instr after reset", {18'h0, `INSTR_RST}, rd);
		bus_xfer(1'b0, `REG_CLASS, 32'h0, rd);
		check("class after reset", 32'h00000200, rd);
	endtask

	// Port reads from pins and timer prescaler clear
	task automatic test_port_timer();
		wr_reg(`REG_CTRL, 32'h1);
		decode(14'h0786, 8'h00);
		check("pins", 32'h1, {31'h0, cls[13]});
		decode(14'h0706, 8'h00);
		check("pins d0", 32'h0, {31'h0, cls[13]});
		decode(14'h0086, 8'h00);
		check("pins move", 32'h0, {31'h0, cls[13]});
		decode(14'h0781, 8'h00);
		check("presc", 32'h1, {31'h0, cls[14]});
		wr_reg(`REG_CTRL, 32'h0);
		bus_xfer(1'b0, `REG_CLASS, 32'h0, cls);
		check("presc off", 32'h0, {31'h0, cls[14]});
	endtask

	initial begin
		errors = 0;
		checks_done = 0;
		reset_n = 1'b0;
		avs_address = 5'h00;
		avs_byteenable = 4'hF;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		fetch_addr = 4'h0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		test_reset_map();
		test_byte_ops();
		test_skips();
		test_literals();
		test_port_timer();
		test_misc_ops();
		test_mid_reset();
		finish_test();
	end
endmodule // risc_instruction_decoder_tb_top
